// file: core/lqm_compare.sv
// per-parameter limit comparison
`timescale 1ns/1ps
module lqm_compare
	import lqm_pkg::*;
#(
	parameter int PW = LQM_PW
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// inputs
	input wire logic i_active,
	input wire logic [PW-1:0] i_value,
	input wire logic [PW-1:0] i_low,
	input wire logic [PW-1:0] i_high,
	// violations, registered
	output logic o_high_hit,
	output logic o_low_hit
);
	// an at-max high limit or at-min low limit can never be crossed
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_high_hit <= 1'b0;
			o_low_hit <= 1'b0;
		end else begin
			o_high_hit <= i_active && (i_value > i_high);
			o_low_hit <= i_active && (i_value < i_low);
		end
	end
endmodule

// file: core/lqm_limit_bank.sv
// threshold storage for the five monitored parameters
`timescale 1ns/1ps
module lqm_limit_bank
	import lqm_pkg::*;
#(
	parameter int PW = LQM_PW
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// write port
	input wire logic i_write,
	input wire logic [2:0] i_select,
	input wire logic i_high,
	input wire logic [PW-1:0] i_value,
	// limits, one per parameter
	output logic [LQM_NPARAM-1:0][PW-1:0] o_low,
	output logic [LQM_NPARAM-1:0][PW-1:0] o_high
);
	// limits reset wide open so no check fires before software programs them
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_low <= '{default: LQM_LOW_LIMIT_RST};
			o_high <= '{default: LQM_HIGH_LIMIT_RST};
		end else if (i_write && (i_select < 3'(LQM_NPARAM))) begin
			if (i_high) begin
				o_high[i_select] <= i_value;
			end else begin
				o_low[i_select] <= i_value;
			end
		end
	end
endmodule

// file: core/lqm_top.sv
// link quality monitor: registers, warning flags, interrupt, link reset
// What this block does
// - monitor only when enabled with 100Mb link
// - first violation per arming raises interrupt if its enable set; a monitor read re-arms
// - monitor read returns flags then clears, re-arms
// - bits 9/8 frequency control high/low
// - bits 7/6 frequency offset high/low
// - bits 5/4 baseline wander high/low
// - bits 3/2 gain control high/low
// - bits 1/0 equalizer coefficient high/low
// - bits 14:10 ignore writes, read zero
// - automatic 100Mb link reset on warnings
// - selector picks parameter, bit picks low/high
// - write strobe loads limit, reads zero
`timescale 1ns/1ps
module lqm_top
	import lqm_pkg::*;
#(
	parameter int PW = LQM_PW,
	parameter int RESET_CYC = LQM_LINK_RESET_CYC
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_rst_n,
	// register port
	input wire logic [LQM_AW-1:0] i_addr,
	input wire logic [LQM_DW-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [LQM_DW-1:0] o_rdata,
	// receiver status and adapted parameters
	input wire logic i_link_100_valid,
	input wire logic [PW-1:0] i_eq_coeff,
	input wire logic [PW-1:0] i_gain_level,
	input wire logic [PW-1:0] i_wander_corr,
	input wire logic [PW-1:0] i_freq_offset,
	input wire logic [PW-1:0] i_freq_control,
	// outputs
	output logic o_irq,
	output logic o_link_reset
);
	logic enable_r;
	logic [LQM_NWARN-1:0] warn_r;
	logic [LQM_NWARN-1:0] warn_hit;
	logic [LQM_NWARN-1:0] warn_nxt;
	logic [2:0] select_r;
	logic high_sel_r;
	logic [LQM_NINT-1:0] int_stat_r;
	logic [LQM_NINT-1:0] int_en_r;
	logic [LQM_NINT-1:0] int_event;
	logic auto_reset_en_r;
	logic armed_r;
	logic [LQM_NPARAM-1:0][PW-1:0] low_lim;
	logic [LQM_NPARAM-1:0][PW-1:0] high_lim;
	logic [LQM_NPARAM-1:0][PW-1:0] params;
	logic active;
	logic limit_write;
	logic rd_monitor;
	logic new_warn;
	logic reset_done;
	lqm_rst_state_t rs_r;
	lqm_rst_state_t rs_nxt;
	logic [$clog2(RESET_CYC+1)-1:0] rs_cnt_r;

	function automatic logic hit(input logic [LQM_AW-1:0] a, input logic [LQM_AW-1:0] k);
		return a == k;
	endfunction

	assign active = enable_r && i_link_100_valid;
	assign limit_write = i_wr && hit(i_addr, LQM_ADDR_ACCESS) && i_wdata[LQM_BIT_WSTROBE];
	assign rd_monitor = i_rd && hit(i_addr, LQM_ADDR_MONITOR);

	// indexed by selector code
	assign params[LQM_SEL_EQ_COEFF] = i_eq_coeff;
	assign params[LQM_SEL_GAIN] = i_gain_level;
	assign params[LQM_SEL_WANDER] = i_wander_corr;
	assign params[LQM_SEL_FOFFSET] = i_freq_offset;
	assign params[LQM_SEL_FCTRL] = i_freq_control;

	lqm_limit_bank #(
		.PW(PW)
	) u_bank (
		.i_clock(i_clock),
		.i_rst_n(i_rst_n),
		.i_write(limit_write),
		.i_select(i_wdata[LQM_SEL_MSB:LQM_SEL_LSB]),
		.i_high(i_wdata[LQM_BIT_HILO]),
		.i_value(i_wdata[LQM_DATA_MSB:0]),
		.o_low(low_lim),
		.o_high(high_lim)
	);

	// warning bit 2k is low, 2k+1 is high, k is the selector code
	for (genvar k = 0; k < LQM_NPARAM; k++) begin : g_cmp
		lqm_compare #(
			.PW(PW)
		) u_cmp (
			.i_clock(i_clock),
			.i_rst_n(i_rst_n),
			.i_active(active),
			.i_value(params[k]),
			.i_low(low_lim[k]),
			.i_high(high_lim[k]),
			.o_high_hit(warn_hit[2*k+1]),
			.o_low_hit(warn_hit[2*k])
		);
	end

	// a hit in the read cycle survives the clear
	always_comb begin
		warn_nxt = rd_monitor ? warn_hit : (warn_r | warn_hit);
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			warn_r <= '0;
		end else begin
			warn_r <= warn_nxt;
		end
	end

	// one interrupt event per arming; a read re-arms
	assign new_warn = armed_r && (|warn_hit);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			armed_r <= 1'b1;
		end else if (new_warn) begin
			armed_r <= 1'b0;
		end else if (rd_monitor) begin
			armed_r <= 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			enable_r <= 1'b0;
			select_r <= 3'h0;
			high_sel_r <= 1'b0;
			int_en_r <= '0;
			auto_reset_en_r <= 1'b0;
		end else if (i_wr) begin
			if (hit(i_addr, LQM_ADDR_MONITOR)) begin
				enable_r <= i_wdata[LQM_BIT_ENABLE];
			end
			if (hit(i_addr, LQM_ADDR_ACCESS)) begin
				select_r <= i_wdata[LQM_SEL_MSB:LQM_SEL_LSB];
				high_sel_r <= i_wdata[LQM_BIT_HILO];
			end
			if (hit(i_addr, LQM_ADDR_INT_EN)) begin
				int_en_r <= i_wdata[LQM_NINT-1:0];
			end
			if (hit(i_addr, LQM_ADDR_RESET_CTL)) begin
				auto_reset_en_r <= i_wdata[LQM_BIT_AUTO_RESET];
			end
		end
	end

	assign int_event[LQM_INT_WARN] = new_warn;
	assign int_event[LQM_INT_RESET] = reset_done;

	// set beats clear in the same cycle
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_stat_r <= '0;
		end else if (i_wr && hit(i_addr, LQM_ADDR_INT_CLR)) begin
			int_stat_r <= (int_stat_r & ~i_wdata[LQM_NINT-1:0]) | int_event;
		end else begin
			int_stat_r <= int_stat_r | int_event;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |((int_stat_r | int_event) & int_en_r);
		end
	end

	// link reset: pulse, then wait for the link to drop
	always_comb begin
		rs_nxt = rs_r;
		unique case (rs_r)
			LQM_RS_IDLE: begin
				if (auto_reset_en_r && new_warn) begin
					rs_nxt = LQM_RS_PULSE;
				end
			end
			LQM_RS_PULSE: begin
				if (rs_cnt_r == '0) begin
					rs_nxt = LQM_RS_WAIT;
				end
			end
			LQM_RS_WAIT: begin
				if (!i_link_100_valid) begin
					rs_nxt = LQM_RS_IDLE;
				end
			end
			default: rs_nxt = LQM_RS_IDLE;
		endcase
	end

	assign reset_done = (rs_r == LQM_RS_PULSE) && (rs_cnt_r == '0);

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rs_r <= LQM_RS_IDLE;
			rs_cnt_r <= '0;
			o_link_reset <= 1'b0;
		end else begin
			rs_r <= rs_nxt;
			o_link_reset <= (rs_nxt == LQM_RS_PULSE);
			if (rs_r == LQM_RS_IDLE) begin
				rs_cnt_r <= $bits(rs_cnt_r)'(RESET_CYC - 1);
			end else if (rs_cnt_r != '0) begin
				rs_cnt_r <= rs_cnt_r - 1'b1;
			end
		end
	end

	// read data, one cycle after the strobe; unmapped reads zero
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rdata <= LQM_RESET_VALUE;
		end else begin
			o_rdata <= '0;
			if (i_rd) begin
				if (hit(i_addr, LQM_ADDR_MONITOR)) begin
					o_rdata[LQM_BIT_ENABLE] <= enable_r;
					o_rdata[LQM_WARN_MSB:0] <= warn_r;
				end else if (hit(i_addr, LQM_ADDR_ACCESS)) begin
					o_rdata[LQM_SEL_MSB:LQM_SEL_LSB] <= select_r;
					o_rdata[LQM_BIT_HILO] <= high_sel_r;
					if (select_r < 3'(LQM_NPARAM)) begin
						o_rdata[LQM_DATA_MSB:0] <= high_sel_r ? high_lim[select_r]
							: low_lim[select_r];
					end
				end else if (hit(i_addr, LQM_ADDR_INT_STAT)) begin
					o_rdata[LQM_NINT-1:0] <= int_stat_r;
				end else if (hit(i_addr, LQM_ADDR_INT_EN)) begin
					o_rdata[LQM_NINT-1:0] <= int_en_r;
				end else if (hit(i_addr, LQM_ADDR_RESET_CTL)) begin
					o_rdata[LQM_BIT_AUTO_RESET] <= auto_reset_en_r;
				end
			end
		end
	end
endmodule

// file: dv/lqm_top_asserts.sv
// port-level assertion checker for the link quality monitor
`timescale 1ns/1ps
module lqm_top_asserts
	import lqm_pkg::*;
#(
	parameter int RESET_CYC = LQM_LINK_RESET_CYC
) (
	// watched ports
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic [LQM_AW-1:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [LQM_DW-1:0] o_rdata,
	input wire logic i_link_100_valid,
	input wire logic o_irq,
	input wire logic o_link_reset
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	logic rd_mon;
	logic [2:0] link_hist_r;
	logic [7:0] hi_cnt_r;
	assign rd_mon = i_rd && i_addr == LQM_ADDR_MONITOR;
	// link history and pulse length, cleared with the design so no stale hits survive reset
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			link_hist_r <= 3'h0;
			hi_cnt_r <= 8'h00;
		end else begin
			link_hist_r <= {link_hist_r[1:0], i_link_100_valid};
			hi_cnt_r <= o_link_reset ? hi_cnt_r + 8'h01 : 8'h00;
		end
	end
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == '0)
		else $error("read data outside read slot");
	a_resv_zero: assert property ($past(rd_mon) |-> o_rdata[14:10] == 5'h00)
		else $error("reserved monitor bits not zero");
	a_unmapped_zero: assert property ($past(i_rd) && $past(i_addr) == 5'h00
		|-> o_rdata == '0)
		else $error("unmapped read not zero");
	a_strobe_zero: assert property ($past(i_rd) && $past(i_addr) == LQM_ADDR_ACCESS
		|-> !o_rdata[LQM_BIT_WSTROBE])
		else $error("limit write strobe reads one");
	a_read_clears: assert property (rd_mon && $past(rd_mon, 2) && link_hist_r == 3'h0
		|=> o_rdata[9:0] == 10'h000)
		else $error("warnings without link or after read");
	a_irq_fall: assert property ($fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2))
		else $error("interrupt dropped without a write");
	a_pulse_len: assert property ($fell(o_link_reset) |-> hi_cnt_r == RESET_CYC)
		else $error("link reset pulse length wrong");
	a_pulse_cap: assert property (hi_cnt_r <= RESET_CYC)
		else $error("link reset pulse too long");
	c_irq: cover property ($rose(o_irq));
	c_link_reset: cover property ($fell(o_link_reset));
	c_warn_read: cover property ($past(rd_mon) && o_rdata[9:0] != 10'h000);
endmodule

// file: dv/lqm_top_tb.sv
// self-checking bench for the link quality monitor
`timescale 1ns/1ps
module lqm_top_tb
	import lqm_pkg::*;
;
	localparam int RC = 3;
	logic i_clock = 1'b0;
	logic i_rst_n = 1'b0;
	logic [LQM_AW-1:0] i_addr = '0;
	logic [LQM_DW-1:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic i_link = 1'b0;
	logic [7:0] p [5] = '{default: 8'h80};
	logic [LQM_DW-1:0] o_rdata;
	logic o_irq;
	logic o_link_reset;
	int n_mismatch = 0;
	int compares = 0;
	always #20 i_clock = ~i_clock;
	lqm_top #(.RESET_CYC(RC)) DUT (.i_clock, .i_rst_n, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_link_100_valid(i_link), .i_eq_coeff(p[0]), .i_gain_level(p[1]),
		.i_wander_corr(p[2]), .i_freq_offset(p[3]), .i_freq_control(p[4]), .o_irq, .o_link_reset);
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge i_clock);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clock);
		i_wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [15:0] e);
		@(posedge i_clock);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clock);
		i_rd <= 1'b0;
		#1 chk(o_rdata, e);
	endtask
	task automatic lim(input logic [2:0] s, input logic h, input logic [7:0] v);
		wr(LQM_ADDR_ACCESS, {4'h1, s, h, v});
	endtask
	task automatic t_regs();
		rd(LQM_ADDR_MONITOR, 16'h0000);
		rd(5'h00, 16'h0000);
		wr(LQM_ADDR_MONITOR, 16'hFFFF);
		rd(LQM_ADDR_MONITOR, 16'h8000);
		for (int s = 0; s < 5; s++) begin
			for (int h = 0; h < 2; h++) begin
				lim(s[2:0], h[0], 8'h40 | {h[0], 7'h00});
				rd(LQM_ADDR_ACCESS, {4'h0, s[2:0], h[0], 8'h40 | {h[0], 7'h00}});
			end
		end
		// an unused selector code stores nothing and reads back no limit
		lim(3'h5, 1'b1, 8'h11);
		rd(LQM_ADDR_ACCESS, 16'h0B00);
		$display("t_regs done");
	endtask
	task automatic t_warn();
		wr(LQM_ADDR_INT_EN, 16'h0001);
		i_link <= 1'b1;
		for (int k = 0; k < 10; k++) begin
			p[k/2] <= k[0] ? 8'hC1 : 8'h3F;
			cyc(3);
			chk({15'h0000, o_irq}, 16'h0001);
			// back within limits before the read, so the flag must have stuck
			p[k/2] <= 8'h80;
			cyc(3);
			rd(LQM_ADDR_MONITOR, 16'h8000 | (16'h1 << k));
			wr(LQM_ADDR_INT_CLR, 16'h0001);
			cyc(1);
			chk({15'h0000, o_irq}, 16'h0000);
		end
		lim(3'h0, 1'b1, 8'hFF);
		lim(3'h1, 1'b0, 8'h00);
		p <= '{8'hFF, 8'h00, 8'hC0, 8'h40, 8'h80};
		cyc(3);
		rd(LQM_ADDR_MONITOR, 16'h8000);
		i_link <= 1'b0;
		p[4] <= 8'hFF;
		cyc(3);
		rd(LQM_ADDR_MONITOR, 16'h8000);
		rd(LQM_ADDR_MONITOR, 16'h8000);
		// link comes back only once the monitor is off, else the held-high value is caught
		wr(LQM_ADDR_MONITOR, 16'h0000);
		i_link <= 1'b1;
		cyc(3);
		rd(LQM_ADDR_MONITOR, 16'h0000);
		p[4] <= 8'h80;
		$display("t_warn done");
	endtask
	task automatic t_mask();
		int n;
		wr(LQM_ADDR_INT_EN, 16'h0000);
		wr(LQM_ADDR_RESET_CTL, 16'h0001);
		wr(LQM_ADDR_MONITOR, 16'h8000);
		p[4] <= 8'hFF;
		for (n = 0; n < 10 && o_link_reset !== 1'b1; n++) cyc(1);
		for (n = 0; n < 20 && o_link_reset === 1'b1; n++) cyc(1);
		chk(16'(n), 16'(RC));
		chk({15'h0000, o_irq}, 16'h0000);
		rd(LQM_ADDR_INT_STAT, 16'h0003);
		wr(LQM_ADDR_INT_EN, 16'h0001);
		cyc(1);
		chk({15'h0000, o_irq}, 16'h0001);
		$display("t_mask done");
	endtask
	task automatic finish_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_clock);
		i_rst_n <= 1'b1;
		t_regs();
		t_warn();
		t_mask();
		finish_test();
	end
	// tests need well under 1000 cycles
	initial begin
		#100000;
		n_mismatch++;
		finish_test();
	end
endmodule
bind lqm_top lqm_top_asserts #(.RESET_CYC(RESET_CYC)) u_chk (.i_clock, .i_rst_n, .i_addr,
	.i_wr, .i_rd, .o_rdata, .i_link_100_valid, .o_irq, .o_link_reset);

// file: pkg/lqm_pkg.sv
// constants and types shared by the link quality monitor files
package lqm_pkg;
	localparam int LQM_AW = 5;
	localparam int LQM_DW = 16;
	localparam int LQM_PW = 8;
	localparam int LQM_NPARAM = 5;
	localparam int LQM_NWARN = 10;
	// register indices
	localparam logic [LQM_AW-1:0] LQM_ADDR_MONITOR = 5'h1D;
	localparam logic [LQM_AW-1:0] LQM_ADDR_ACCESS = 5'h1E;
	localparam logic [LQM_AW-1:0] LQM_ADDR_INT_STAT = 5'h10;
	localparam logic [LQM_AW-1:0] LQM_ADDR_INT_CLR = 5'h11;
	localparam logic [LQM_AW-1:0] LQM_ADDR_INT_EN = 5'h12;
	localparam logic [LQM_AW-1:0] LQM_ADDR_RESET_CTL = 5'h13;
	// monitor register fields
	localparam int LQM_BIT_ENABLE = 15;
	localparam int LQM_WARN_MSB = 9;
	// access register fields
	localparam int LQM_BIT_WSTROBE = 12;
	localparam int LQM_SEL_MSB = 11;
	localparam int LQM_SEL_LSB = 9;
	localparam int LQM_BIT_HILO = 8;
	localparam int LQM_DATA_MSB = 7;
	// parameter selector codes
	localparam logic [2:0] LQM_SEL_EQ_COEFF = 3'h0;
	localparam logic [2:0] LQM_SEL_GAIN = 3'h1;
	localparam logic [2:0] LQM_SEL_WANDER = 3'h2;
	localparam logic [2:0] LQM_SEL_FOFFSET = 3'h3;
	localparam logic [2:0] LQM_SEL_FCTRL = 3'h4;
	// interrupt and reset-control fields
	localparam int LQM_INT_WARN = 0;
	localparam int LQM_INT_RESET = 1;
	localparam int LQM_NINT = 2;
	localparam int LQM_BIT_AUTO_RESET = 0;
	localparam logic [LQM_DW-1:0] LQM_RESET_VALUE = 16'h0000;
	localparam logic [LQM_PW-1:0] LQM_LOW_LIMIT_RST = 8'h00;
	localparam logic [LQM_PW-1:0] LQM_HIGH_LIMIT_RST = 8'hFF;
	// link reset pulse timing
	localparam int LQM_CLOCK_HZ = 25000000;
	localparam int LQM_LINK_RESET_US = 1;
	localparam int LQM_LINK_RESET_CYC = (LQM_CLOCK_HZ / 1000000) * LQM_LINK_RESET_US;

	typedef enum logic [2:0] {
		LQM_RS_IDLE = 3'b001,
		LQM_RS_PULSE = 3'b010,
		LQM_RS_WAIT = 3'b100
	} lqm_rst_state_t;
endpackage
